/* File: fmrs_host.sv */
// host model that clocks serial frames into the device
`timescale 1ns/1ps
module fmrs_host (
  // link pins
  output logic o_link_clk,
  output logic o_sync_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  initial begin
    o_link_clk = 1'b0;
    o_sync_n = 1'b1;
    o_sdi = 1'b0;
  end
  // clock stands still between frames; a short n makes a broken frame
  task automatic frame(input logic [23:0] w, input int n, output logic [23:0] r);
    r = 24'h000000;
    o_sync_n = 1'b0;
    #20;
    for (int k = 0; k < n; k++) begin
      o_sdi = w[23-k];
      #62.5 o_link_clk = 1'b1;
      #62.5 r[23-k] = i_sdo;
      o_link_clk = 1'b0;
    end
    #62.5 o_sync_n = 1'b1;
    // released line shows junk, never the last bit
    o_sdi = ~o_sdi;
    #150;
  endtask
endmodule

/* File: fmrs_link.sv */
// serial link shifter running on the link clock
`timescale 1ns/1ps
module fmrs_link
  import fmrs_pkg::*;
(
  // link pins
  input wire logic i_link_clk,
  input wire logic i_sync_n,
  input wire logic i_sdi,
  output logic o_sdo,
  // reset
  input wire logic i_resetn,
  // system side, quasi-static between frames
  input wire logic [23:0] i_tx_word,
  input wire logic i_tx_en,
  output logic [23:0] o_rx_word,
  output logic [4:0] o_rx_count
);
  typedef struct packed {
    logic [4:0] count;
    logic [23:0] rx;
    logic [23:0] tx;
    logic serial_out_line;
  } fmrs_link_s;

  fmrs_link_s st_reg;
  fmrs_link_s st_next;
  logic start_reg;

  // armed by the frame select itself, since the link clock is idle between frames
  always_ff @(posedge i_link_clk or posedge i_sync_n) begin
    if (i_sync_n) begin
      start_reg <= 1'b1;
    end else begin
      start_reg <= 1'b0;
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.rx = {st_reg.rx[22:0], i_sdi};
    if (start_reg) begin
      st_next.count = 5'h01;
      st_next.serial_out_line = i_tx_en & i_tx_word[23];
      st_next.tx = {i_tx_word[22:0], 1'b0};
    end else begin
      if (st_reg.count != 5'h1F) begin
        st_next.count = st_reg.count + 5'h01;
      end
      st_next.serial_out_line = i_tx_en & st_reg.tx[23];
      st_next.tx = {st_reg.tx[22:0], 1'b0};
    end
  end

  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_sdo = st_reg.serial_out_line;
  assign o_rx_word = st_reg.rx;
  assign o_rx_count = st_reg.count;
endmodule

/* File: fmrs_pkg.sv */
// constants and types shared by the alarm mask and readout pick logic
package fmrs_pkg;
  localparam int FMRS_FRAME_BITS = 24;
  localparam int FMRS_CNT_W = 5;
  localparam logic [4:0] FMRS_FRAME_LEN = 5'h18;
  // frame layout: device address, register address, data
  localparam int FMRS_DEV_HI = 23;
  localparam int FMRS_DEV_LO = 22;
  localparam int FMRS_ADR_HI = 20;
  localparam int FMRS_ADR_LO = 16;
  localparam int FMRS_FAULT_BIT = 21;
  // register addresses
  localparam logic [4:0] FMRS_ADDR_NOP = 5'h00;
  localparam logic [4:0] FMRS_ADDR_DAC_IN = 5'h01;
  localparam logic [4:0] FMRS_ADDR_DAC_OUT = 5'h02;
  localparam logic [4:0] FMRS_ADDR_ALARM_MASK = 5'h12;
  localparam logic [4:0] FMRS_ADDR_READOUT_PICK = 5'h13;
  localparam logic [4:0] FMRS_ADDR_STATUS = 5'h16;
  // reset values
  localparam logic [15:0] FMRS_MASK_RST = 16'h0000;
  localparam logic [1:0] FMRS_MODE_RST = 2'h0;
  localparam logic [4:0] FMRS_TARGET_RST = 5'h00;
  localparam logic [21:0] FMRS_ALARM_MASK_RST = 22'h120000;
  localparam logic [21:0] FMRS_READOUT_PICK_RST = 22'h130000;
  // alarm mask bit positions
  localparam int FMRS_M_SPI_ACCESS = 15;
  localparam int FMRS_M_OVERVOLT = 14;
  localparam int FMRS_M_INV_CODE = 12;
  localparam int FMRS_M_CLK_HALT = 10;
  localparam int FMRS_M_LATCH_MON = 9;
  localparam int FMRS_M_WATCHDOG = 8;
  localparam int FMRS_M_SLIP = 7;
  localparam int FMRS_M_CRC = 6;
  localparam int FMRS_M_BUCK_SHORT = 4;
  localparam int FMRS_M_OPEN_CIRC = 3;
  localparam int FMRS_M_VOLT_SHORT = 2;
  localparam int FMRS_M_BUCK_HEAT = 1;
  localparam int FMRS_M_MAIN_HEAT = 0;
  // readout pick field positions
  localparam int FMRS_MODE_HI = 6;
  localparam int FMRS_MODE_LO = 5;
  localparam int FMRS_TGT_HI = 4;
  localparam int FMRS_TGT_LO = 0;
  typedef enum logic [1:0] {
    FMRS_RB_TWO_STAGE = 2'h0,
    FMRS_RB_AUTO = 2'h1,
    FMRS_RB_SHARED = 2'h2,
    FMRS_RB_ALTERNATE = 2'h3
  } fmrs_mode_e;
endpackage

/* File: fmrs_top.sv */
// alarm mask and readout pick registers with serial readback selection
`timescale 1ns/1ps
module fmrs_top
  import fmrs_pkg::*;
(
  // system clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // serial link
  input wire logic i_link_clk,
  input wire logic i_sync_n,
  input wire logic i_sdi,
  output logic o_sdo,
  // hardware address pins
  input wire logic [1:0] i_hw_addr,
  // error flags from the detectors
  input wire logic i_spi_access_flag,
  input wire logic i_output_overvoltage_flag,
  input wire logic i_inverted_code_check_flag,
  input wire logic i_clock_halt_flag,
  input wire logic i_latch_monitor_flag,
  input wire logic i_watchdog_timeout_flag,
  input wire logic i_frame_slip_flag,
  input wire logic i_serial_crc_flag,
  input wire logic i_buck_short_flag,
  input wire logic i_current_open_circuit_flag,
  input wire logic i_voltage_short_flag,
  input wire logic i_buck_die_heat_flag,
  input wire logic i_main_die_heat_flag,
  // readback sources
  input wire logic [15:0] i_status_word,
  input wire logic [15:0] i_dac_input_word,
  input wire logic [15:0] i_dac_output_word,
  // fault pin and frame status
  output logic o_fault_n,
  output logic o_frame_err
);
  typedef struct packed {
    logic [2:0] sync_pipe;
    logic [1:0] hwa_s1;
    logic [1:0] hwa_s2;
    logic [15:0] mask;
    logic [1:0] mode;
    logic [4:0] target;
    logic wr_flag;
    logic alt;
    logic [23:0] prev_instr;
    logic [23:0] tx_word;
    logic tx_en;
    logic fault_n;
    logic frame_err;
  } fmrs_sys_s;

  fmrs_sys_s st_reg;
  fmrs_sys_s st_next;

  logic [23:0] rx_word;
  logic [4:0] rx_count;
  logic [15:0] err_vec;
  logic frame_end;
  logic frame_ok;
  logic frame_write;
  logic [4:0] frame_addr;
  logic [15:0] frame_data;
  logic [21:0] alarm_mask_val;
  logic [21:0] readout_pick_val;

  // link side; its words only change while the link clock runs inside a frame
  fmrs_link u_link (
    .i_link_clk(i_link_clk),
    .i_sync_n(i_sync_n),
    .i_sdi(i_sdi),
    .o_sdo(o_sdo),
    .i_resetn(i_resetn),
    .i_tx_word(st_reg.tx_word),
    .i_tx_en(st_reg.tx_en),
    .o_rx_word(rx_word),
    .o_rx_count(rx_count)
  );

  // error flags placed at their mask positions; reserved positions stay zero
  always_comb begin
    err_vec = 16'h0000;
    err_vec[FMRS_M_SPI_ACCESS] = i_spi_access_flag;
    err_vec[FMRS_M_OVERVOLT] = i_output_overvoltage_flag;
    err_vec[FMRS_M_INV_CODE] = i_inverted_code_check_flag;
    err_vec[FMRS_M_CLK_HALT] = i_clock_halt_flag;
    err_vec[FMRS_M_LATCH_MON] = i_latch_monitor_flag;
    err_vec[FMRS_M_WATCHDOG] = i_watchdog_timeout_flag;
    err_vec[FMRS_M_SLIP] = i_frame_slip_flag;
    err_vec[FMRS_M_CRC] = i_serial_crc_flag;
    err_vec[FMRS_M_BUCK_SHORT] = i_buck_short_flag;
    err_vec[FMRS_M_OPEN_CIRC] = i_current_open_circuit_flag;
    err_vec[FMRS_M_VOLT_SHORT] = i_voltage_short_flag;
    err_vec[FMRS_M_BUCK_HEAT] = i_buck_die_heat_flag;
    err_vec[FMRS_M_MAIN_HEAT] = i_main_die_heat_flag;
  end

  // register read values
  always_comb begin
    alarm_mask_val = {~st_reg.fault_n, FMRS_ADDR_ALARM_MASK, st_reg.mask};
    readout_pick_val = {~st_reg.fault_n, FMRS_ADDR_READOUT_PICK, 9'h000,
                        st_reg.mode, st_reg.target};
  end

  // frame decode: the rx word is stable once the frame select has risen
  always_comb begin
    frame_end = st_reg.sync_pipe[1] & ~st_reg.sync_pipe[2];
    frame_addr = rx_word[FMRS_ADR_HI:FMRS_ADR_LO];
    frame_data = rx_word[15:0];
    frame_ok = (rx_count == FMRS_FRAME_LEN);
    frame_write = frame_ok & (rx_word[FMRS_DEV_HI:FMRS_DEV_LO] == st_reg.hwa_s2);
  end

  // word returned for a given register address
  function automatic logic [23:0] fmrs_read(
    input logic [4:0] addr,
    input logic [15:0] mask,
    input logic [1:0] mode,
    input logic [4:0] target,
    input logic fault_n,
    input logic [15:0] dac_in,
    input logic [15:0] dac_out,
    input logic [15:0] status
  );
    logic [15:0] data;
    data = 16'h0000;
    unique case (addr)
      FMRS_ADDR_NOP: data = 16'h0000;
      FMRS_ADDR_DAC_IN: data = dac_in;
      FMRS_ADDR_DAC_OUT: data = dac_out;
      FMRS_ADDR_ALARM_MASK: data = mask;
      FMRS_ADDR_READOUT_PICK: data = {9'h000, mode, target};
      FMRS_ADDR_STATUS: data = status;
      default: data = 16'h0000;
    endcase
    return {2'b00, ~fault_n, addr, data};
  endfunction

  always_comb begin
    st_next = st_reg;
    // two flops before any logic sees the pins
    st_next.sync_pipe = {st_reg.sync_pipe[1:0], i_sync_n};
    st_next.hwa_s1 = i_hw_addr;
    st_next.hwa_s2 = st_reg.hwa_s1;
    // fault pin follows unmasked errors with one cycle of delay
    st_next.fault_n = ~|(err_vec & ~st_reg.mask);
    st_next.frame_err = 1'b0;
    if (frame_end) begin
      st_next.frame_err = ~frame_ok;
      st_next.prev_instr = rx_word;
      st_next.wr_flag = frame_write;
      st_next.alt = ~st_reg.alt;
      if (frame_write) begin
        if (frame_addr == FMRS_ADDR_ALARM_MASK) begin
          st_next.mask = frame_data;
        end
        if (frame_addr == FMRS_ADDR_READOUT_PICK) begin
          st_next.mode = frame_data[FMRS_MODE_HI:FMRS_MODE_LO];
          st_next.target = frame_data[FMRS_TGT_HI:FMRS_TGT_LO];
        end
      end
    end
    // prepare the next outgoing word; it is frozen while a frame runs
    if (st_reg.sync_pipe[2] & st_reg.sync_pipe[1] & ~frame_end) begin
      st_next.tx_en = 1'b1;
      unique case (fmrs_mode_e'(st_reg.mode))
        FMRS_RB_TWO_STAGE: begin
          st_next.tx_word = fmrs_read(st_reg.target, st_reg.mask, st_reg.mode,
                                      st_reg.target, st_reg.fault_n, i_dac_input_word,
                                      i_dac_output_word, i_status_word);
          // own registers come back in their full read layout
          if (st_reg.target == FMRS_ADDR_ALARM_MASK) begin
            st_next.tx_word = {2'b00, alarm_mask_val};
          end
          if (st_reg.target == FMRS_ADDR_READOUT_PICK) begin
            st_next.tx_word = {2'b00, readout_pick_val};
          end
        end
        FMRS_RB_AUTO: begin
          st_next.tx_word = fmrs_read(FMRS_ADDR_STATUS, st_reg.mask, st_reg.mode,
                                      st_reg.target, st_reg.fault_n, i_dac_input_word,
                                      i_dac_output_word, i_status_word);
        end
        FMRS_RB_SHARED: begin
          st_next.tx_en = st_reg.wr_flag;
          st_next.tx_word = fmrs_read(FMRS_ADDR_STATUS, st_reg.mask, st_reg.mode,
                                      st_reg.target, st_reg.fault_n, i_dac_input_word,
                                      i_dac_output_word, i_status_word);
        end
        FMRS_RB_ALTERNATE: begin
          if (st_reg.alt) begin
            st_next.tx_word = st_reg.prev_instr;
          end else begin
            st_next.tx_word = fmrs_read(FMRS_ADDR_STATUS, st_reg.mask, st_reg.mode,
                                        st_reg.target, st_reg.fault_n, i_dac_input_word,
                                        i_dac_output_word, i_status_word);
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '0;
      st_reg.sync_pipe <= 3'h7;
      st_reg.mask <= FMRS_MASK_RST;
      st_reg.mode <= FMRS_MODE_RST;
      st_reg.target <= FMRS_TARGET_RST;
      st_reg.fault_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_fault_n = st_reg.fault_n;
  assign o_frame_err = st_reg.frame_err;
endmodule

/* File: fmrs_top_bench.sv */
// bench for the alarm mask and readout pick logic
`timescale 1ns/1ps
module fmrs_top_bench;
  import fmrs_pkg::*;
  typedef struct packed {logic [15:0] mask; logic [15:0] flg; logic fault_n;} fmrs_row_s;
  localparam logic [1:0] HW = 2'h2;
  localparam logic [23:0] ST = {3'b000, FMRS_ADDR_STATUS, 16'hA5C3};
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_link_clk, i_sync_n, i_sdi, o_sdo, o_fault_n, o_frame_err;
  logic [15:0] flg = 16'h0000;
  logic [23:0] r, r1;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int errs = 0;
  // reserved mask bits stay zero in every row
  fmrs_row_s rows [7] = '{'{16'h0000, 16'hD7DF, 1'b0}, '{16'hD7DF, 16'hD7DF, 1'b1},
    '{16'hC000, 16'hC000, 1'b1}, '{16'h1700, 16'h1700, 1'b1}, '{16'h00DF, 16'h00DF, 1'b1},
    '{16'hD7DE, 16'h0001, 1'b0}, '{16'h57DF, 16'h8000, 1'b0}};
  always #4 i_sys_clk = ~i_sys_clk;
  fmrs_host fmrs_host_inst (.o_link_clk(i_link_clk), .o_sync_n(i_sync_n), .o_sdi(i_sdi),
    .i_sdo(o_sdo));
  fmrs_top fmrs_top_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_link_clk(i_link_clk),
    .i_sync_n(i_sync_n), .i_sdi(i_sdi), .o_sdo(o_sdo), .i_hw_addr(HW),
    .i_spi_access_flag(flg[15]), .i_output_overvoltage_flag(flg[14]),
    .i_inverted_code_check_flag(flg[12]), .i_clock_halt_flag(flg[10]),
    .i_latch_monitor_flag(flg[9]), .i_watchdog_timeout_flag(flg[8]),
    .i_frame_slip_flag(flg[7]), .i_serial_crc_flag(flg[6]), .i_buck_short_flag(flg[4]),
    .i_current_open_circuit_flag(flg[3]), .i_voltage_short_flag(flg[2]),
    .i_buck_die_heat_flag(flg[1]), .i_main_die_heat_flag(flg[0]),
    .i_status_word(16'hA5C3), .i_dac_input_word(16'h1234), .i_dac_output_word(16'hFEDC),
    .o_fault_n(o_fault_n), .o_frame_err(o_frame_err));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic [1:0] dev, input logic [4:0] a, input logic [15:0] d);
    fmrs_host_inst.frame({dev, 1'b0, a, d}, 24, r);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ceiling sized for about a hundred frames
  always @(posedge i_sys_clk) begin
    cycles++;
    if (o_frame_err === 1'b1) errs++;
    if (cycles == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    repeat (8) @(negedge i_sys_clk);
    xfer(HW, FMRS_ADDR_READOUT_PICK, 16'h0012);
    xfer(HW, FMRS_ADDR_NOP, 16'h0000);
    check(r, 24'(FMRS_ALARM_MASK_RST));
    foreach (rows[i]) begin
      xfer(HW, FMRS_ADDR_ALARM_MASK, rows[i].mask);
      @(negedge i_sys_clk) flg = rows[i].flg;
      repeat (3) @(negedge i_sys_clk);
      check({23'h0, o_fault_n}, {23'h0, rows[i].fault_n});
      xfer(HW, FMRS_ADDR_NOP, 16'h0000);
      xfer(HW, FMRS_ADDR_NOP, 16'h0000);
      check(r, {2'b00, ~rows[i].fault_n, FMRS_ADDR_ALARM_MASK, rows[i].mask});
    end
    // a 23-bit frame must leave the mask alone
    fmrs_host_inst.frame({HW, 1'b0, FMRS_ADDR_ALARM_MASK, 16'hFFFF}, 23, r);
    repeat (8) @(negedge i_sys_clk);
    check({23'h0, o_fault_n}, 24'h0);
    check(24'(errs), 24'h1);
    @(negedge i_sys_clk) flg = 16'h0000;
    for (int t = 1; t < 3; t++) begin
      xfer(HW, FMRS_ADDR_READOUT_PICK, 16'(t));
      xfer(HW, FMRS_ADDR_NOP, 16'h0000);
      check(r, {3'b000, 5'(t), (t == 1) ? 16'h1234 : 16'hFEDC});
    end
    xfer(HW, FMRS_ADDR_READOUT_PICK, 16'h0020);
    xfer(HW, FMRS_ADDR_NOP, 16'h0000);
    check(r, ST);
    xfer(HW, FMRS_ADDR_READOUT_PICK, 16'h0040);
    xfer(2'h1, FMRS_ADDR_NOP, 16'h0000);
    check(r, ST);
    xfer(HW, FMRS_ADDR_NOP, 16'h0000);
    check(r, 24'h0);
    xfer(HW, FMRS_ADDR_READOUT_PICK, 16'h0060);
    // 34 frames since reset, an even count, so status leads; dev 0 keeps the echo header zero
    xfer(2'h0, FMRS_ADDR_NOP, 16'h00AA);
    r1 = r;
    xfer(HW, FMRS_ADDR_NOP, 16'h0055);
    check(r1, ST);
    check(r, {2'h0, 6'h00, 16'h00AA});
    // second reset in mid-run must clear the masks again
    @(negedge i_sys_clk) flg = 16'h0001;
    xfer(HW, FMRS_ADDR_ALARM_MASK, 16'h0001);
    @(negedge i_sys_clk);
    check({23'h0, o_fault_n}, 24'h1);
    i_resetn = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    check({23'h0, o_fault_n}, 24'h1);
    i_resetn = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    check({23'h0, o_fault_n}, 24'h0);
    tally_and_finish();
  end
endmodule

/* File: fmrs_top_sva.sv */
// assertions on the fault pin, frame error pulse and readback header
`timescale 1ns/1ps
module fmrs_top_sva (
  // clocks, reset and frame select
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_link_clk,
  input wire logic i_sync_n,
  // error flags
  input wire logic i_spi_access_flag,
  input wire logic i_output_overvoltage_flag,
  input wire logic i_inverted_code_check_flag,
  input wire logic i_clock_halt_flag,
  input wire logic i_latch_monitor_flag,
  input wire logic i_watchdog_timeout_flag,
  input wire logic i_frame_slip_flag,
  input wire logic i_serial_crc_flag,
  input wire logic i_buck_short_flag,
  input wire logic i_current_open_circuit_flag,
  input wire logic i_voltage_short_flag,
  input wire logic i_buck_die_heat_flag,
  input wire logic i_main_die_heat_flag,
  // outputs
  input wire logic o_sdo,
  input wire logic o_fault_n,
  input wire logic o_frame_err
);
  logic any_flag;
  logic seen_reg;
  logic [4:0] bit_reg;
  assign any_flag = |{i_spi_access_flag, i_output_overvoltage_flag,
    i_inverted_code_check_flag, i_clock_halt_flag, i_latch_monitor_flag,
    i_watchdog_timeout_flag, i_frame_slip_flag, i_serial_crc_flag, i_buck_short_flag,
    i_current_open_circuit_flag, i_voltage_short_flag, i_buck_die_heat_flag,
    i_main_die_heat_flag};
  // masks are known to be zero only until the first frame starts
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) seen_reg <= 1'b0;
    else if (!i_sync_n) seen_reg <= 1'b1;
  end
  always_ff @(posedge i_link_clk or posedge i_sync_n) begin
    if (i_sync_n) bit_reg <= 5'h00;
    else bit_reg <= bit_reg + 5'h01;
  end
  sequence s_two_quiet;
    !any_flag [*2];
  endsequence
  property p_quiet;
    @(posedge i_sys_clk) disable iff (!i_resetn) !any_flag |=> o_fault_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("fault pin low with no flag");
  property p_unmasked;
    @(posedge i_sys_clk) disable iff (!i_resetn) (!seen_reg && any_flag) |=> !o_fault_n;
  endproperty
  a_unmasked: assert property (p_unmasked) else $error("flag blocked after reset");
  property p_recover;
    @(posedge i_sys_clk) disable iff (!i_resetn) any_flag ##1 s_two_quiet |-> o_fault_n;
  endproperty
  a_recover: assert property (p_recover) else $error("fault pin stuck low");
  property p_release;
    @(posedge i_sys_clk) disable iff (!i_resetn) $rose(i_resetn) |-> o_fault_n && !o_frame_err;
  endproperty
  a_release: assert property (p_release) else $error("outputs not idle at release");
  property p_pulse;
    @(posedge i_sys_clk) disable iff (!i_resetn) o_frame_err |=> !o_frame_err;
  endproperty
  a_pulse: assert property (p_pulse) else $error("frame error longer than one cycle");
  property p_err_high;
    @(posedge i_sys_clk) disable iff (!i_resetn) o_frame_err |-> i_sync_n;
  endproperty
  a_err_high: assert property (p_err_high) else $error("frame error inside a frame");
  property p_err_late;
    @(posedge i_sys_clk) disable iff (!i_resetn) o_frame_err |-> !$past(i_sync_n, 8);
  endproperty
  a_err_late: assert property (p_err_late) else $error("frame error without a frame");
  property p_hdr;
    @(negedge i_link_clk) disable iff (!i_resetn)
      (!i_sync_n && bit_reg inside {5'h01, 5'h02}) |-> !o_sdo;
  endproperty
  a_hdr: assert property (p_hdr) else $error("readback header bits not zero");
endmodule
bind fmrs_top fmrs_top_sva fmrs_top_sva_inst (
  .i_sys_clk(i_sys_clk),
  .i_resetn(i_resetn),
  .i_link_clk(i_link_clk),
  .i_sync_n(i_sync_n),
  .i_spi_access_flag(i_spi_access_flag),
  .i_output_overvoltage_flag(i_output_overvoltage_flag),
  .i_inverted_code_check_flag(i_inverted_code_check_flag),
  .i_clock_halt_flag(i_clock_halt_flag),
  .i_latch_monitor_flag(i_latch_monitor_flag),
  .i_watchdog_timeout_flag(i_watchdog_timeout_flag),
  .i_frame_slip_flag(i_frame_slip_flag),
  .i_serial_crc_flag(i_serial_crc_flag),
  .i_buck_short_flag(i_buck_short_flag),
  .i_current_open_circuit_flag(i_current_open_circuit_flag),
  .i_voltage_short_flag(i_voltage_short_flag),
  .i_buck_die_heat_flag(i_buck_die_heat_flag),
  .i_main_die_heat_flag(i_main_die_heat_flag),
  .o_sdo(o_sdo),
  .o_fault_n(o_fault_n),
  .o_frame_err(o_frame_err)
);
